/* rtl/smc_pkg.sv */
// smc_pkg: constants and types for the system monitor control core
// assumes one 125 MHz clock; shared by core and tach counter
package smc_pkg;
  localparam int          CLK_MHZ         = 125;
  localparam logic [4:0]  ADDR_FIXED      = 5'h0B;
  localparam logic [1:0]  SEL_GND         = 2'h0;
  localparam logic [1:0]  SEL_OPEN        = 2'h1;
  localparam logic [1:0]  SEL_VCC         = 2'h2;
  localparam logic [1:0]  ALO_GND         = 2'h0;
  localparam logic [1:0]  ALO_OPEN        = 2'h2;
  localparam logic [1:0]  ALO_VCC         = 2'h1;
  localparam int          NCH             = 19;
  localparam int          NFAN            = 8;
  localparam int          CHW             = 5;
  localparam logic [4:0]  CH_D2_T         = 5'h11;
  localparam logic [4:0]  CH_D2_A         = 5'h12;
  localparam int          RST_PULSE_MS    = 180;
  localparam int          RST_CYC         = RST_PULSE_MS * CLK_MHZ * 1000;
  localparam int          PWM_HZ          = 75;
  localparam int          PWM_PERIOD      = (CLK_MHZ * 1000000) / PWM_HZ;
  localparam int          PWM_STEP        = PWM_PERIOD / 256;
  localparam logic [15:0] NV_BASE         = 16'h8000;
  localparam logic [15:0] NV_LAST         = 16'h9FFF;
  localparam int          CFG_INT_EN      = 1;
  localparam logic [7:0]  CFG_RST         = 8'h00;
  localparam logic [7:0]  PWM_RST         = 8'hFF;
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam int          INTR_BIT        = 6;
  typedef enum logic [1:0] {SMC_IDLE, SMC_CONV, SMC_STORE} smc_seq_type;
endpackage : smc_pkg

/* rtl/smc_tach_if.sv */
// smc_tach_if: groups one fan tachometer counter's signals
// assumes the core drives divisor and enable
`timescale 1ns/1ps
interface smc_tach_if;
  logic [1:0] div;
  logic       en;
  logic       pulse;
  logic [7:0] count;
  modport ctl (output div, output en, output pulse, input count);
  modport cnt (input div, input en, input pulse, output count);
endinterface : smc_tach_if

/* rtl/smc_tach.sv */
// smc_tach: one fan speed counter with divisor prescaler
// assumes tach pulses already synchronous to ref_clk
`timescale 1ns/1ps
module smc_tach (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // counter side
  smc_tach_if.cnt   t
);
  import smc_pkg::*;
  logic [7:0]  pre_q;
  logic [7:0]  run_q;
  logic [3:0]  edges_q;
  logic        prev_q;
  logic [3:0]  need;
  assign need = 4'(1) << t.div;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // idle pin level is high, so no false edge after reset
      prev_q <= 1'b1;
    end else begin
      prev_q <= t.pulse;
    end
  end
  // R19 divisor sets edges per reading; prescale fixed at 256 cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q   <= 8'h00;
      run_q   <= 8'h00;
      edges_q <= 4'h0;
    end else if (!t.en) begin
      run_q   <= 8'h00;
      edges_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 8'h01;
      if (pre_q == 8'hFF && run_q != 8'hFF) begin
        run_q <= run_q + 8'h01;
      end
      if (t.pulse && !prev_q) begin
        if (edges_q + 4'h1 >= need) begin
          edges_q <= 4'h0;
          run_q   <= 8'h00;
        end else begin
          edges_q <= edges_q + 4'h1;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t.count <= 8'hFF;
    end else if (t.en && t.pulse && !prev_q && edges_q + 4'h1 >= need) begin
      t.count <= run_q;
    end
  end
endmodule : smc_tach

/* rtl/smc_core.sv */
// smc_core: system monitor control core, serial slave side decoded outside
// assumes bus framing done by a byte-level engine; analog converter external
`timescale 1ns/1ps
// How it works
// R1 - slave address high bits fixed 01011
// R2 - select pin sets two low bits
// R3 - open select answers at 5Ch
// R4 - select pin latched once, first transaction
// R5 - first write byte loads address pointer
// R6 - sequencer steps channels, fans run parallel
// R7 - each result stored, readable by host
// R8 - limit violations set status bits
// R9 - out-of-limit drives active-low interrupt
// R10 - mask bits block status sources
// R11 - intrusion bit latched until cleared
// R12 - rail resets held 180 ms
// R13 - main reset pin also reset input
// R14 - open-drain PWM at 75 Hz
// R15 - 8-bit code to fan converter
// R16 - conversion results are 8 bits
// R17 - nonvolatile window 8000h to 9FFFh
// R18 - host writes nonvolatile only when blank
// R19 - fan counters use divisor prescaler
// R20 - GPIO config sets direction and polarity
// R21 - tach pins usable as GPIO
// R22 - second diode pair temperature or analog
// R23 - interrupt disabled until config bit 1
// R24 - sequencer wraps to first channel
module smc_core #(
  parameter int RST_CYCLES = smc_pkg::RST_CYC
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // byte engine side of serial bus
  input  wire logic                       bus_start,
  input  wire logic [6:0]                 bus_addr,
  input  wire logic                       bus_wr,
  input  wire logic                       bus_first,
  input  wire logic [7:0]                 bus_wdata,
  output logic                            bus_match,
  output logic [15:0]                     ptr_q,
  output logic                            ptr_nv,
  // address select pin, decoded three states
  input  wire logic [1:0]                 addr_sel,
  // configuration
  input  wire logic                       mon_start,
  input  wire logic [7:0]                 cfg_reg,
  input  wire logic [15:0]                fan_div,
  input  wire logic [7:0]                 pwm_duty,
  input  wire logic [7:0]                 dac_in,
  input  wire logic                       pwm_invert,
  input  wire logic [7:0]                 tach_is_gpio,
  input  wire logic                       d2_is_temp,
  input  wire logic [7:0]                 gpio_dir,
  input  wire logic [7:0]                 gpio_pol,
  input  wire logic [7:0]                 gpio_dout,
  input  wire logic [smc_pkg::NCH*8-1:0]  lim_hi,
  input  wire logic [smc_pkg::NCH*8-1:0]  lim_lo,
  input  wire logic [smc_pkg::NCH-1:0]    int_mask,
  input  wire logic                       intr_clr,
  input  wire logic [smc_pkg::NCH-1:0]    stat_clr,
  // converter handshake
  output logic                            conv_req,
  output logic [4:0]                      conv_ch,
  output logic                            conv_temp,
  input  wire logic                       conv_done,
  input  wire logic [7:0]                 conv_data,
  // results
  output logic [smc_pkg::NCH*8-1:0]       value_q,
  output logic [smc_pkg::NFAN*8-1:0]      fan_q,
  output logic [smc_pkg::NCH-1:0]         stat_q,
  output logic                            intr_q,
  output logic [7:0]                      gpio_din,
  // pins
  input  wire logic [7:0]                 tach_in,
  output logic [7:0]                      tach_oe,
  input  wire logic                       intrusion_in,
  output logic                            int_n_oe,
  output logic                            pwm_oe,
  output logic [7:0]                      dac_code_q,
  input  wire logic                       stby_ok,
  input  wire logic                       main_ok,
  output logic                            standby_rail_reset,
  output logic                            main_rail_reset_o,
  output logic                            main_rail_reset_oe,
  input  wire logic                       main_rail_reset_i,
  output logic                            core_rst_n
);
  import smc_pkg::*;

  logic              locked_q;
  logic [1:0]        alo_q;
  logic [1:0]        alo_d;
  smc_seq_type       st_q;
  logic [4:0]        ch_q;
  logic [31:0]       stby_cnt_q;
  logic [31:0]       main_cnt_q;
  logic [31:0]       pwm_cnt_q;
  logic [7:0]        pwm_gate;
  logic              pwm_hi;
  logic [7:0]        hi_v;
  logic [7:0]        lo_v;
  logic              skip_ch;
  logic              int_pend;

  // R2 select pin decode
  always_comb begin
    case (addr_sel)
      SEL_GND:  alo_d = ALO_GND;
      SEL_OPEN: alo_d = ALO_OPEN;
      SEL_VCC:  alo_d = ALO_VCC;
      default:  alo_d = ALO_OPEN;
    endcase
  end

  // R4 latch select once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      locked_q <= 1'b0;
      alo_q    <= 2'h0;
    end else if (bus_start && !locked_q) begin
      locked_q <= 1'b1;
      alo_q    <= alo_d;
    end
  end

  // R1 R3 address compare, open gives 5Ch
  assign bus_match = bus_start &&
                     bus_addr == {ADDR_FIXED, (locked_q ? alo_q : alo_d)};

  // R5 first write byte to pointer; R17 window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= 16'h0000;
    end else if (bus_wr && bus_first) begin
      ptr_q <= {8'h00, bus_wdata};
    end else if (bus_wr) begin
      ptr_q <= {ptr_q[7:0], bus_wdata};
    end
  end
  // R17 nonvolatile decode; R18 blank check left to host
  assign ptr_nv = ptr_q >= NV_BASE && ptr_q <= NV_LAST;

  // R22 second diode pair usage
  always_comb begin
    skip_ch = 1'b0;
    if (ch_q == CH_D2_A && d2_is_temp) begin
      skip_ch = 1'b1;
    end
  end
  assign conv_temp = (ch_q == CH_D2_T) && d2_is_temp;
  assign conv_ch   = ch_q;
  // skipped channel asks the converter for nothing
  assign conv_req  = st_q == SMC_CONV && !skip_ch;

  // R6 R24 sequencer stepping and wrap
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= SMC_IDLE;
      ch_q <= 5'h00;
    end else begin
      case (st_q)
        SMC_IDLE: begin
          if (mon_start) begin
            st_q <= SMC_CONV;
          end
        end
        SMC_CONV: begin
          if (skip_ch) begin
            st_q <= SMC_STORE;
          end else if (conv_done) begin
            st_q <= SMC_STORE;
          end
        end
        SMC_STORE: begin
          ch_q <= (ch_q == 5'(NCH - 1)) ? 5'h00 : ch_q + 5'h01;
          st_q <= mon_start ? SMC_CONV : SMC_IDLE;
        end
        default: st_q <= SMC_IDLE;
      endcase
    end
  end

  // R7 R16 store 8-bit result
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= '0;
    end else if (st_q == SMC_CONV && conv_done && !skip_ch) begin
      value_q[ch_q*8 +: 8] <= conv_data;
    end
  end

  assign hi_v = lim_hi[ch_q*8 +: 8];
  assign lo_v = lim_lo[ch_q*8 +: 8];

  // R8 sticky status, set wins over clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (st_q == SMC_CONV && conv_done && !skip_ch && ch_q == 5'(i) &&
            (conv_data > hi_v || conv_data < lo_v)) begin
          stat_q[i] <= 1'b1;
        end else if (stat_clr[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  // R11 intrusion latch
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intr_q <= 1'b0;
    end else if (intrusion_in) begin
      intr_q <= 1'b1;
    end else if (intr_clr) begin
      intr_q <= 1'b0;
    end
  end

  // R10 mask gating
  assign int_pend = |(stat_q & ~int_mask);
  // R9 R23 active-low interrupt, enabled by config
  assign int_n_oe = int_pend && cfg_reg[CFG_INT_EN];

  // R19 R21 fan counters
  genvar g;
  generate
    for (g = 0; g < NFAN; g++) begin : g_fan
      smc_tach_if tif ();
      assign tif.div   = fan_div[g*2 +: 2];
      assign tif.en    = mon_start && !tach_is_gpio[g];
      assign tif.pulse = tach_in[g];
      assign fan_q[g*8 +: 8] = tif.count;
      smc_tach u_tach (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .t       (tif)
      );
    end
  endgenerate

  // R20 R21 direction and polarity
  assign tach_oe  = tach_is_gpio & gpio_dir & ~(gpio_dout ^ gpio_pol);
  assign gpio_din = tach_in ^ gpio_pol;

  // R14 75 Hz PWM
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_cnt_q <= 32'h0;
    end else if (pwm_cnt_q == 32'(PWM_PERIOD - 1)) begin
      pwm_cnt_q <= 32'h0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 32'h1;
    end
  end
  // saturate so the period tail never wraps to step zero
  assign pwm_gate = (pwm_cnt_q >= 32'(PWM_STEP * 255)) ? 8'hFF : 8'(pwm_cnt_q / 32'(PWM_STEP));
  assign pwm_hi   = (pwm_duty == 8'hFF) || (pwm_gate < pwm_duty);
  assign pwm_oe   = pwm_hi ^ ~pwm_invert;

  // R15 converter code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dac_code_q <= 8'h00;
    end else begin
      dac_code_q <= dac_in;
    end
  end

  // R12 standby reset pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stby_cnt_q <= 32'h0;
    end else if (!stby_ok) begin
      stby_cnt_q <= 32'h0;
    end else if (stby_cnt_q != 32'(RST_CYCLES)) begin
      stby_cnt_q <= stby_cnt_q + 32'h1;
    end
  end
  assign standby_rail_reset = stby_cnt_q == 32'(RST_CYCLES);

  // R12 main reset after standby
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      main_cnt_q <= 32'h0;
    end else if (!main_ok || !standby_rail_reset) begin
      main_cnt_q <= 32'h0;
    end else if (main_cnt_q != 32'(RST_CYCLES)) begin
      main_cnt_q <= main_cnt_q + 32'h1;
    end
  end
  assign main_rail_reset_o  = 1'b0;
  assign main_rail_reset_oe = main_cnt_q != 32'(RST_CYCLES);
  // R13 external pull low resets
  assign core_rst_n = main_rail_reset_i && !main_rail_reset_oe;

  // assertions
  // R4 address stays locked
  lock_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    locked_q |=> locked_q && alo_q == $past(alo_q)) else $error("address lock lost");
  // R3 open select answers 5Ch
  addr_open_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    (bus_start && !locked_q && addr_sel == SEL_OPEN && {bus_addr, 1'b0} == 8'h5C) |-> bus_match)
    else $error("5Ch not matched");
  // R5 pointer load
  ptr_load_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
    (bus_wr && bus_first) |=> ptr_q == {8'h00, $past(bus_wdata)}) else $error("pointer not loaded");
  // R7 value store
  val_store_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    (st_q == SMC_CONV && conv_done && !skip_ch) |=> value_q[$past(ch_q)*8 +: 8] == $past(conv_data))
    else $error("value not stored");
  // R8 limit sets status
  lim_stat_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R8
    (st_q == SMC_CONV && conv_done && !skip_ch && conv_data > hi_v) |=> stat_q[$past(ch_q)])
    else $error("status not set");
  // R23 interrupt gated by config
  int_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R23
    !cfg_reg[CFG_INT_EN] |-> !int_n_oe) else $error("interrupt while disabled");
  // R11 intrusion sticky
  intr_stick_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
    intrusion_in |=> intr_q ##1 (intr_q || $past(intr_clr))) else $error("intrusion lost");
  // R24 sequencer wraps
  seq_wrap_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R24
    (st_q == SMC_STORE && ch_q == 5'(NCH - 1)) |=> ch_q == 5'h00) else $error("no wrap");
endmodule : smc_core

/* sim/smc_conv_model.sv */
// smc_conv_model: converter standing behind the core's handshake
// assumes conv_req held until conv_done is seen
`timescale 1ns/1ps
module smc_conv_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // handshake
  input  wire logic conv_req,
  output logic      conv_done,
  output logic [7:0] conv_data
);
  int   wait_n = 0;
  int   seed   = 42756;
  logic fire;
  initial begin
    conv_done = 1'b0;
    conv_data = 8'h00;
  end
  always @(posedge ref_clk) begin
    #1;
    fire = rstn && conv_req === 1'b1 && wait_n == 0;
    if (!rstn) wait_n = 0;
    else if (fire) wait_n = {$random(seed)} % 8;
    else if (conv_req === 1'b1) wait_n--;
    conv_done = fire;
    // released data lines flip so a stale value never passes
    conv_data = fire ? 8'($random(seed)) : ~conv_data;
  end
endmodule : smc_conv_model

/* sim/tb.sv */
// tb: self-checking bench for smc_core with a result model
// assumes smc_pkg and smc_conv_model compiled first
`timescale 1ns/1ps
module tb;
  import smc_pkg::*;
  logic            ref_clk, rstn, bus_start, bus_wr, bus_first, mon_start, pwm_invert, d2_is_temp;
  logic            intr_clr, intrusion_in, stby_ok, main_ok, ext_n, conv_done;
  logic            bus_match, ptr_nv, conv_req, conv_temp, int_n_oe, pwm_oe;
  logic            standby_rail_reset, main_rail_reset_oe, main_rail_reset_i, core_rst_n, intr_q, main_rail_reset_o;
  logic [6:0]      bus_addr, ads [3];
  logic [1:0]      addr_sel, sels [3];
  logic [7:0]      bus_wdata, cfg_reg, pwm_duty, dac_in, tach_is_gpio, gpio_dir, gpio_pol, gpio_dout;
  logic [7:0]      conv_data, tach_in, gpio_din, tach_oe, dac_code_q, pend_d;
  logic [4:0]      conv_ch;
  logic [15:0]     fan_div, ptr_q, pa [5];
  logic [NCH*8-1:0] lim_hi, lim_lo, value_q;
  logic [NFAN*8-1:0] fan_q;
  logic [NCH-1:0]  int_mask, stat_clr, stat_q, stat_m;
  int              failures, samples_checked, seed, exp_ch, pend, n_conv;

  // pin pulled up, low while either party drives it
  assign main_rail_reset_i = ext_n & ~main_rail_reset_oe;

  smc_core #(.RST_CYCLES(100)) dut (
    .ref_clk, .rstn, .bus_start, .bus_addr, .bus_wr, .bus_first, .bus_wdata, .bus_match, .ptr_q, .ptr_nv,
    .addr_sel, .mon_start, .cfg_reg, .fan_div, .pwm_duty, .dac_in, .pwm_invert, .tach_is_gpio, .d2_is_temp,
    .gpio_dir, .gpio_pol, .gpio_dout, .lim_hi, .lim_lo, .int_mask, .intr_clr, .stat_clr, .conv_req, .conv_ch,
    .conv_temp, .conv_done, .conv_data, .value_q, .fan_q, .stat_q, .intr_q, .gpio_din, .tach_in, .tach_oe,
    .intrusion_in, .int_n_oe, .pwm_oe, .dac_code_q, .stby_ok, .main_ok, .standby_rail_reset,
    .main_rail_reset_o, .main_rail_reset_oe, .main_rail_reset_i, .core_rst_n);

  smc_conv_model conv (.ref_clk, .rstn, .conv_req, .conv_done, .conv_data);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic do_reset();
    rstn = 1'b0;
    mon_start = 1'b0;
    cyc(4);
    rstn = 1'b1;
  endtask : do_reset

  task automatic start(input logic [6:0] a, input logic m);
    bus_addr = a;
    bus_start = 1'b1;
    #2 chk(bus_match, m);
    cyc(1);
    bus_start = 1'b0;
    cyc(1);
  endtask : start

  task automatic wr(input logic [7:0] d, input logic f);
    bus_wdata = d;
    bus_first = f;
    bus_wr = 1'b1;
    cyc(1);
    bus_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic run(input int n);
    for (int k = 0; k < 4000 && n_conv < n; k++) cyc(1);
    // stalled sequencer counts as a mismatch
    if (n_conv < n) failures++;
  endtask : run

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  always @(posedge ref_clk) begin
    if (!rstn) begin
      exp_ch = 0;
      stat_m = '0;
      pend = -1;
      n_conv = 0;
    end else begin
      if (pend >= 0) begin
        chk(value_q[pend*8+:8], pend_d);
        chk(stat_q, stat_m);
        pend = -1;
      end
      stat_m = stat_m & ~stat_clr;
      if (conv_done === 1'b1) begin
        chk(conv_ch, exp_ch);
        if (d2_is_temp && exp_ch == CH_D2_T) chk(conv_temp, 1'b1);
        pend = exp_ch;
        pend_d = conv_data;
        if (conv_data > lim_hi[exp_ch*8+:8] || conv_data < lim_lo[exp_ch*8+:8]) stat_m[exp_ch] = 1'b1;
        n_conv++;
        exp_ch = exp_ch + 1 + int'(d2_is_temp && exp_ch + 1 == CH_D2_A);
        if (exp_ch >= NCH) exp_ch = 0;
      end
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    summarize();
  end

  initial begin
    seed = 42756;
    {bus_start, bus_wr, bus_first, pwm_invert, d2_is_temp, intr_clr, intrusion_in} = '0;
    {stby_ok, main_ok, ext_n} = 3'h7;
    {bus_addr, bus_wdata, cfg_reg, dac_in, tach_is_gpio, gpio_dir, gpio_pol, gpio_dout} = '0;
    {int_mask, stat_clr} = '0;
    addr_sel = SEL_OPEN;
    fan_div = 16'($random(seed));
    pwm_duty = 8'hFF;
    tach_in = 8'hFF;
    lim_hi = {NCH{8'hC0}};
    lim_lo = {NCH{8'h40}};
    sels = '{SEL_GND, SEL_OPEN, SEL_VCC};
    ads = '{7'h2C, 7'h2E, 7'h2D};
    pa = '{16'h8000, 16'h9FFF, 16'hA000, 16'h7FFF, 16'h0000};
    pa[4] = 16'($random(seed));
    do_reset();
    // address per select state, then locked
    for (int i = 0; i < 3; i++) begin
      addr_sel = sels[i];
      do_reset();
      start(ads[i], 1'b1);
      start({5'b01010, ads[i][1:0]}, 1'b0);
      addr_sel = (i == 0) ? SEL_VCC : SEL_GND;
      start(ads[i], 1'b1);
      start((i == 0) ? 7'h2D : 7'h2C, 1'b0);
    end
    $display("test address done");
    // pointer only, no data into nonvolatile
    for (int i = 0; i < 5; i++) begin
      wr(pa[i][15:8], 1'b1);
      wr(pa[i][7:0], 1'b0);
      chk(ptr_q, pa[i]);
      chk(ptr_nv, pa[i] >= 16'h8000 && pa[i] <= 16'h9FFF);
    end
    $display("test pointer done");
    mon_start = 1'b1;
    run(21);
    chk(int_n_oe, 1'b0);
    cfg_reg = 8'h02;
    run(40);
    chk(int_n_oe, |stat_m);
    $display("test sequence done");
    d2_is_temp = 1'b1;
    int_mask = '1;
    do_reset();
    mon_start = 1'b1;
    run(10);
    stat_clr = '1;
    intr_clr = 1'b1;
    cyc(1);
    stat_clr = '0;
    intr_clr = 1'b0;
    run(40);
    chk(int_n_oe, 1'b0);
    $display("test mask done");
    do_reset();
    chk(standby_rail_reset, 1'b0);
    chk(main_rail_reset_oe, 1'b1);
    chk(main_rail_reset_o, 1'b0);
    cyc(300);
    chk(standby_rail_reset, 1'b1);
    chk(main_rail_reset_oe, 1'b0);
    {stby_ok, main_ok} = 2'h0;
    cyc(3);
    chk(standby_rail_reset, 1'b0);
    chk(main_rail_reset_oe, 1'b1);
    {stby_ok, main_ok} = 2'h3;
    cyc(300);
    ext_n = 1'b0;
    cyc(2);
    chk(core_rst_n, 1'b0);
    ext_n = 1'b1;
    $display("test resets done");
    // fans count, upper four pins held as GPIO
    for (int g = 0; g < NFAN; g++) chk(fan_q[g*8+:8], 8'hFF);
    tach_is_gpio = 8'hF0;
    mon_start = 1'b1;
    repeat (64) begin
      tach_in = ~tach_in;
      cyc(2);
    end
    for (int g = 0; g < NFAN; g++) chk(fan_q[g*8+:8] < 8'h02, g < 4);
    $display("test fans done");
    for (int i = 0; i < 4; i++) begin
      {tach_in, gpio_pol, gpio_dir, gpio_dout} = $random(seed);
      tach_is_gpio = 8'($random(seed));
      dac_in = 8'($random(seed));
      intrusion_in = i[0];
      pwm_duty = i[0] ? 8'hFF : 8'h00;
      pwm_invert = i[1];
      cyc(2);
      chk(gpio_din, tach_in ^ gpio_pol);
      chk(tach_oe, tach_is_gpio & gpio_dir & ~(gpio_dout ^ gpio_pol));
      chk(dac_code_q, dac_in);
      chk(pwm_oe, (pwm_duty == 8'h00) ^ pwm_invert);
      chk(intr_q, i != 0);
    end
    // set and clear in one cycle: set wins, then a plain clear
    intr_clr = 1'b1;
    cyc(1);
    chk(intr_q, 1'b1);
    intrusion_in = 1'b0;
    cyc(1);
    intr_clr = 1'b0;
    cyc(1);
    chk(intr_q, 1'b0);
    $display("test pins done");
    summarize();
  end
endmodule : tb
